/* File: core/fciw_crc_step.sv */
// One byte step of a parameterised CRC
`timescale 1ns/100ps
module fciw_crc_step #(
    parameter int W = 32,
    parameter logic [W-1:0] POLY = '0,
    parameter bit REFL = 1'b0
) (
    // Check value in and out
    input wire logic [W-1:0] crc_in,
    input wire logic [7:0] data,
    output logic [W-1:0] crc_out
);
    always_comb begin
        logic [W-1:0] c;
        logic fb;
        c = crc_in;
        fb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (REFL) begin
                fb = c[0] ^ data[i];
                c = (c >> 1) ^ (fb ? POLY : '0);
            end else begin
                fb = c[W-1] ^ data[7-i];
                c = (c << 1) ^ (fb ? POLY : '0);
            end
        end
        crc_out = c;
    end
endmodule : fciw_crc_step

/* File: core/fciw_top.sv */
// Frame relay to AAL-5 cell network interworking datapath
`timescale 1ns/100ps
// Operation
// - One frame relay frame per AAL-5 PDU, both directions.
// - Under congestion, cells with the loss priority bit set are dropped.
// - AAL-5 framing stripped toward frames, added toward cells.
// - Outgoing frame sent only once fully reassembled, payload unchanged.
// - Configured DLCI written into every outgoing frame header.
// - Outgoing frames are flag delimited and carry a frame check sequence.
// - End-to-end loopback cells with the indication bit set are returned unless one is pending, never passed to frames.
// - Far-end receive failure cells are terminated locally.
// - AIS is translated into the other network's construct.
// - VPI/VCI and DLCI are mapped per connection.
// - Convergence PDU equals the core frame without flags or FCS.
// - A trailer is appended to each frame before segmentation.
// - The convergence PDU is cut into 48-byte payloads.
// - Each payload gets a cell header prefix.
// - Cells to frames run the same layers in reverse.
// - Outgoing cells use the internal cell header format.
// - Congestion bits are copied between frame and cell headers.
// - Frames are rebuilt from internal packets before segmentation.
// - Rate policing applies per connection from its setup.
// - Optionally, frame DE is copied to every cell's CLP.
module fciw_top #(
    parameter int AIS_CYCLES = fciw_pkg::AIS_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Connection setup and status
    input wire fciw_pkg::fciw_cfg_t cfg,
    input wire logic net_congested,
    input wire logic fr_alarm,
    // Frame side, internal packet bus in
    input wire fciw_pkg::fciw_byte_t pkt_in,
    output logic pkt_ready,
    // Frame side out
    output fciw_pkg::fciw_byte_t frame_out,
    output logic fr_ais,
    // Cell side
    input wire fciw_pkg::fciw_byte_t cell_in,
    output logic cell_ready,
    output fciw_pkg::fciw_byte_t cell_out,
    // Status
    output logic ferf,
    output logic frame_err,
    output logic [15:0] err_count
);
    localparam logic [25:0] AIS_RELOAD = 26'(AIS_CYCLES - 1);

    typedef struct packed {
        logic pkt_ready;
        logic tx_full;
        logic tx_ovf;
        logic [9:0] tx_len;
        logic tx_fecn;
        logic tx_de;
        logic tx_busy;
        fciw_pkg::fciw_kind_t tx_kind;
        logic tx_last;
        logic tx_drop;
        logic [5:0] tx_hb;
        logic [10:0] tx_pos;
        logic [31:0] tx_hdr;
        logic [31:0] tx_crc;
        logic [7:0] hec;
        logic [15:0] credit;
        fciw_pkg::fciw_byte_t cell_out;
        logic loop_pend;
        logic ais_pend;
        logic [25:0] ais_timer;
        fciw_pkg::fciw_rx_t rx_st;
        logic cell_ready;
        logic [5:0] rx_hb;
        logic [31:0] rx_hdr;
        logic [10:0] rx_base;
        logic [31:0] rx_crc;
        logic [15:0] rx_len;
        logic rx_fecn;
        logic rx_de;
        logic rx_ovf;
        logic [7:0] rx_otype;
        logic [10:0] rx_pos;
        logic [15:0] fcs;
        fciw_pkg::fciw_byte_t frame_out;
        logic fr_ais;
        logic ferf;
        logic frame_err;
        logic [15:0] err_count;
    } fciw_state_t;

    fciw_state_t s;
    fciw_state_t next_s;
    logic [7:0] tx_mem [0:fciw_pkg::BUF_DEPTH-1];
    logic [7:0] rx_mem [0:fciw_pkg::BUF_DEPTH-1];
    logic [7:0] loop_mem [0:47];
    logic tx_we, rx_we, lp_we;
    logic [9:0] tx_wa, rx_wa;
    logic [5:0] lp_wa;
    logic [7:0] tx_b, rx_b, hec_b;
    logic [31:0] tx_crc_next, rx_crc_next;
    logic [7:0] hec_next;
    logic [15:0] fcs_next;

    fciw_crc_step #(.W(32), .POLY(fciw_pkg::CRC32_POLY), .REFL(1'b0))
        u_tx_crc (.crc_in(s.tx_crc), .data(tx_b), .crc_out(tx_crc_next));
    fciw_crc_step #(.W(32), .POLY(fciw_pkg::CRC32_POLY), .REFL(1'b0))
        u_rx_crc (.crc_in(s.rx_crc), .data(cell_in.data),
                  .crc_out(rx_crc_next));
    fciw_crc_step #(.W(8), .POLY(fciw_pkg::HEC_POLY), .REFL(1'b0))
        u_hec (.crc_in(s.hec), .data(hec_b), .crc_out(hec_next));
    fciw_crc_step #(.W(16), .POLY(fciw_pkg::FCS16_POLY), .REFL(1'b1))
        u_fcs (.crc_in(s.fcs), .data(rx_b), .crc_out(fcs_next));

    always_comb begin
        logic [16:0] csum;
        logic [5:0] k;
        logic [5:0] rk;
        logic [5:0] hb;
        logic [7:0] ob;
        logic clp;
        logic short;
        logic match;
        logic [10:0] total;
        logic [16:0] lenx;
        logic [10:0] idx;
        next_s = s;
        csum = {1'b0, s.credit} + {9'h000, cfg.credit_inc};
        k = s.tx_hb - fciw_pkg::HB_PAY;
        rk = 6'h00;
        hb = 6'h00;
        ob = 8'h00;
        clp = 1'b0;
        short = 1'b0;
        match = 1'b0;
        total = 11'h000;
        lenx = 17'h00000;
        idx = 11'h000;
        tx_we = 1'b0;
        tx_wa = s.tx_len;
        rx_we = 1'b0;
        rx_wa = 10'h000;
        lp_we = 1'b0;
        lp_wa = 6'h00;
        tx_b = 8'h00;
        hec_b = 8'h00;
        rx_b = 8'h00;
        next_s.cell_out = '0;
        next_s.frame_out = '0;
        next_s.fr_ais = 1'b0;
        next_s.frame_err = 1'b0;
        // Token bucket fill
        next_s.credit = (csum > {1'b0, cfg.credit_max}) ? cfg.credit_max
                                                      : csum[15:0];
        // AIS generation toward cells while the frame side is in alarm
        if (s.ais_timer != 26'h0000000) begin
            next_s.ais_timer = s.ais_timer - 26'h0000001;
        end else if (fr_alarm) begin
            next_s.ais_pend = 1'b1;
            next_s.ais_timer = AIS_RELOAD;
        end
        // Frame collection from internal packets
        if (pkt_in.valid && s.pkt_ready) begin
            if (s.tx_len == fciw_pkg::LEN_MAX) begin
                next_s.tx_ovf = 1'b1;
            end else begin
                tx_we = 1'b1;
                next_s.tx_len = s.tx_len + 10'h001;
            end
            if (pkt_in.last) begin
                if (!next_s.tx_ovf && next_s.tx_len >= fciw_pkg::FR_MIN_LEN
                    && {tx_mem[0][7:2], tx_mem[1][7:4]} == cfg.dlci) begin
                    next_s.tx_full = 1'b1;
                    next_s.pkt_ready = 1'b0;
                    next_s.tx_pos = 11'h000;
                    next_s.tx_crc = '1;
                    next_s.tx_fecn = tx_mem[1][3];
                    next_s.tx_de = tx_mem[1][1];
                end else begin
                    next_s.tx_len = 10'h000;
                    next_s.tx_ovf = 1'b0;
                end
            end
        end
        // Cell transmit: start of a cell
        if (!s.tx_busy) begin
            next_s.tx_hb = 6'h00;
            next_s.hec = 8'h00;
            next_s.tx_drop = 1'b0;
            if (s.loop_pend || s.ais_pend) begin
                next_s.tx_busy = 1'b1;
                next_s.tx_kind = s.loop_pend ? fciw_pkg::KIND_LOOP
                                             : fciw_pkg::KIND_AIS;
                next_s.tx_hdr = {fciw_pkg::HCF_INTERNAL, cfg.vpi, cfg.vci,
                                 2'b00, fciw_pkg::PTI_OAM_E2E, 1'b0};
            end else if (s.tx_full) begin
                lenx = {7'h00, s.tx_len} + fciw_pkg::TRAILER_BYTES;
                clp = cfg.de_to_clp & s.tx_de;
                short = s.credit < fciw_pkg::CELL_COST;
                if (clp || !short) begin
                    next_s.tx_busy = 1'b1;
                    next_s.tx_kind = fciw_pkg::KIND_USER;
                    next_s.tx_last = lenx <= {6'h00, s.tx_pos}
                                     + fciw_pkg::PAYLOAD_BYTES_W;
                    next_s.tx_drop = clp && (short || net_congested);
                    if (!short) begin
                        next_s.credit = next_s.credit - fciw_pkg::CELL_COST;
                    end
                    next_s.tx_hdr = {fciw_pkg::HCF_INTERNAL, cfg.vpi, cfg.vci,
                                     net_congested, 1'b0, 1'b0, s.tx_fecn,
                                     next_s.tx_last, clp};
                end
            end
        end else begin
            // Cell transmit: one byte per clock
            next_s.tx_hb = s.tx_hb + 6'h01;
            if (s.tx_hb < fciw_pkg::HB_HEC) begin
                ob = s.tx_hdr[31:24];
                hec_b = ob;
                next_s.hec = hec_next;
                next_s.tx_hdr = {s.tx_hdr[23:0], 8'h00};
            end else if (s.tx_hb == fciw_pkg::HB_HEC) begin
                ob = s.hec ^ fciw_pkg::HEC_COSET;
            end else begin
                unique case (s.tx_kind)
                    fciw_pkg::KIND_USER: begin
                        if (s.tx_last && k >= fciw_pkg::K_CRC) begin
                            ob = ~s.tx_crc[31:24];
                            next_s.tx_crc = {s.tx_crc[23:0], 8'h00};
                        end else begin
                            if (s.tx_last && k == fciw_pkg::K_LEN_HI) begin
                                tx_b = {6'h00, s.tx_len[9:8]};
                            end else if (s.tx_last && k == fciw_pkg::K_LEN_LO) begin
                                tx_b = s.tx_len[7:0];
                            end else if (s.tx_last && k >= fciw_pkg::K_TRAILER) begin
                                tx_b = 8'h00;
                            end else if (s.tx_pos < {1'b0, s.tx_len}) begin
                                tx_b = tx_mem[s.tx_pos[9:0]];
                            end
                            ob = tx_b;
                            next_s.tx_crc = tx_crc_next;
                        end
                        next_s.tx_pos = s.tx_pos + 11'h001;
                    end
                    fciw_pkg::KIND_LOOP: begin
                        ob = loop_mem[k];
                        if (k == fciw_pkg::LB_IND_IDX) begin
                            ob[0] = 1'b0;
                        end
                    end
                    fciw_pkg::KIND_AIS: begin
                        ob = (k == 6'h00) ? fciw_pkg::OAM_AIS
                                          : fciw_pkg::OAM_FILL;
                    end
                    default: ob = 8'h00;
                endcase
            end
            next_s.cell_out = {~s.tx_drop, s.tx_hb == 6'h00,
                               s.tx_hb == fciw_pkg::HB_LAST, ob};
            if (s.tx_hb == fciw_pkg::HB_LAST) begin
                next_s.tx_busy = 1'b0;
                if (s.tx_kind == fciw_pkg::KIND_LOOP) begin
                    next_s.loop_pend = 1'b0;
                end else if (s.tx_kind == fciw_pkg::KIND_AIS) begin
                    next_s.ais_pend = s.ais_timer == 26'h0000000 && fr_alarm;
                end else if (s.tx_last) begin
                    next_s.tx_full = 1'b0;
                    next_s.pkt_ready = 1'b1;
                    next_s.tx_len = 10'h000;
                end
            end
        end
        // Cell receive and reassembly
        unique case (s.rx_st)
            fciw_pkg::RX_CELL: begin
                if (cell_in.valid) begin
                    hb = cell_in.first ? 6'h00 : s.rx_hb;
                    rk = hb - fciw_pkg::HB_PAY;
                    next_s.rx_hb = hb + 6'h01;
                    match = s.rx_hdr[29:6] == {cfg.vpi, cfg.vci};
                    total = s.rx_base + fciw_pkg::PAYLOAD_BYTES;
                    idx = s.rx_base + {5'h00, rk};
                    if (hb < fciw_pkg::HB_HEC) begin
                        next_s.rx_hdr = {s.rx_hdr[23:0], cell_in.data};
                    end else if (hb >= fciw_pkg::HB_PAY && match) begin
                        if (s.rx_hdr[3:1] == fciw_pkg::PTI_OAM_E2E) begin
                            lp_we = !s.loop_pend;
                            lp_wa = rk;
                            if (rk == 6'h00) begin
                                next_s.rx_otype = cell_in.data;
                            end
                        end else begin
                            next_s.rx_crc = rx_crc_next;
                            rx_wa = idx[9:0];
                            rx_we = idx < fciw_pkg::BUF_LIMIT;
                            next_s.rx_ovf = s.rx_ovf | ~rx_we;
                            if (rk == fciw_pkg::K_LEN_HI) begin
                                next_s.rx_len[15:8] = cell_in.data;
                            end
                            if (rk == fciw_pkg::K_LEN_LO) begin
                                next_s.rx_len[7:0] = cell_in.data;
                            end
                        end
                    end
                    if (hb == fciw_pkg::HB_LAST && match) begin
                        if (s.rx_hdr[3:1] == fciw_pkg::PTI_OAM_E2E) begin
                            if (s.rx_otype == fciw_pkg::OAM_LOOPBACK
                                && !s.loop_pend && loop_mem[1][0]) begin
                                next_s.loop_pend = 1'b1;
                            end
                            if (s.rx_otype == fciw_pkg::OAM_AIS) begin
                                next_s.fr_ais = 1'b1;
                            end
                            if (s.rx_otype == fciw_pkg::OAM_FERF) begin
                                next_s.ferf = 1'b1;
                            end
                        end else begin
                            next_s.ferf = 1'b0;
                            next_s.rx_fecn = s.rx_fecn | s.rx_hdr[2];
                            next_s.rx_de = s.rx_de | s.rx_hdr[0];
                            next_s.rx_base = total;
                            lenx = {1'b0, s.rx_len} + fciw_pkg::TRAILER_BYTES;
                            if (s.rx_hdr[1]) begin
                                next_s.rx_base = 11'h000;
                                next_s.rx_crc = '1;
                                if (rx_crc_next == fciw_pkg::CRC32_RESIDUE
                                    && !next_s.rx_ovf
                                    && s.rx_len >= fciw_pkg::FR_MIN_LEN_RX
                                    && lenx <= {6'h00, total}
                                    && lenx + fciw_pkg::PAYLOAD_BYTES_W
                                       > {6'h00, total}) begin
                                    next_s.rx_st = fciw_pkg::RX_EMIT;
                                    next_s.cell_ready = 1'b0;
                                    next_s.rx_pos = 11'h000;
                                    next_s.fcs = '1;
                                end else begin
                                    next_s.frame_err = 1'b1;
                                    next_s.err_count = s.err_count + 16'h0001;
                                    next_s.rx_ovf = 1'b0;
                                    next_s.rx_fecn = 1'b0;
                                    next_s.rx_de = 1'b0;
                                end
                            end
                        end
                    end
                end
            end
            fciw_pkg::RX_EMIT: begin
                next_s.rx_pos = s.rx_pos + 11'h001;
                idx = s.rx_pos - 11'h001;
                rx_b = rx_mem[idx[9:0]];
                if (idx == 11'h000) begin
                    rx_b = {cfg.dlci[9:4], rx_b[1], 1'b0};
                end else if (idx == 11'h001) begin
                    rx_b = {cfg.dlci[3:0], rx_b[3] | s.rx_fecn, rx_b[2],
                            rx_b[1] | s.rx_de, 1'b1};
                end
                ob = fciw_pkg::HDLC_FLAG;
                if (s.rx_pos != 11'h000 && {5'h00, s.rx_pos} <= s.rx_len) begin
                    ob = rx_b;
                    next_s.fcs = fcs_next;
                end else if ({5'h00, s.rx_pos} == s.rx_len + 16'h0001) begin
                    ob = ~s.fcs[7:0];
                end else if ({5'h00, s.rx_pos} == s.rx_len + 16'h0002) begin
                    ob = ~s.fcs[15:8];
                end else if (s.rx_pos != 11'h000) begin
                    next_s.rx_st = fciw_pkg::RX_CELL;
                    next_s.cell_ready = 1'b1;
                    next_s.rx_fecn = 1'b0;
                    next_s.rx_de = 1'b0;
                end
                next_s.frame_out = {1'b1, s.rx_pos == 11'h000,
                                    next_s.rx_st == fciw_pkg::RX_CELL, ob};
            end
            default: next_s.rx_st = fciw_pkg::RX_CELL;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.pkt_ready <= 1'b1;
            s.cell_ready <= 1'b1;
            s.rx_crc <= '1;
        end else begin
            s <= next_s;
        end
        if (tx_we) begin
            tx_mem[tx_wa] <= pkt_in.data;
        end
        if (rx_we) begin
            rx_mem[rx_wa] <= cell_in.data;
        end
        if (lp_we) begin
            loop_mem[lp_wa] <= cell_in.data;
        end
    end

    assign pkt_ready = s.pkt_ready;
    assign cell_ready = s.cell_ready;
    assign cell_out = s.cell_out;
    assign frame_out = s.frame_out;
    assign fr_ais = s.fr_ais;
    assign ferf = s.ferf;
    assign frame_err = s.frame_err;
    assign err_count = s.err_count;
endmodule : fciw_top

/* File: shared/fciw_pkg.sv */
// Shared constants and types of the frame/cell interworking block
package fciw_pkg;
    // Clock and timing
    localparam int CLK_HZ = 50_000_000;
    localparam int AIS_PERIOD_MS = 1000;
    localparam int AIS_PERIOD_CYCLES = CLK_HZ / 1000 * AIS_PERIOD_MS;

    // Cell layout: byte index within a 53-byte cell
    localparam logic [5:0] HB_HEC = 6'h04;
    localparam logic [5:0] HB_PAY = 6'h05;
    localparam logic [5:0] HB_LAST = 6'h34;
    // Payload index within a cell
    localparam logic [5:0] K_TRAILER = 6'h28;
    localparam logic [5:0] K_LEN_HI = 6'h2A;
    localparam logic [5:0] K_LEN_LO = 6'h2B;
    localparam logic [5:0] K_CRC = 6'h2C;
    localparam logic [5:0] LB_IND_IDX = 6'h01;
    localparam logic [10:0] PAYLOAD_BYTES = 11'h030;
    localparam logic [16:0] TRAILER_BYTES = 17'h00008;
    localparam logic [16:0] PAYLOAD_BYTES_W = 17'h00030;

    // Frame buffers
    localparam int BUF_DEPTH = 1024;
    localparam logic [10:0] BUF_LIMIT = 11'h400;
    localparam logic [9:0] LEN_MAX = 10'h3FF;
    localparam logic [9:0] FR_MIN_LEN = 10'h003;
    localparam logic [15:0] FR_MIN_LEN_RX = 16'h0003;

    // Header codes
    localparam logic [1:0] HCF_INTERNAL = 2'h0;
    localparam logic [2:0] PTI_OAM_E2E = 3'h5;
    localparam logic [7:0] OAM_LOOPBACK = 8'h18;
    localparam logic [7:0] OAM_AIS = 8'h10;
    localparam logic [7:0] OAM_FERF = 8'h11;
    localparam logic [7:0] OAM_FILL = 8'h6A;
    localparam logic [7:0] HDLC_FLAG = 8'h7E;

    // Check sequences
    localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC32_RESIDUE = 32'hC704DD7B;
    localparam logic [15:0] FCS16_POLY = 16'h8408;
    localparam logic [7:0] HEC_POLY = 8'h07;
    localparam logic [7:0] HEC_COSET = 8'h55;

    // Policing
    localparam logic [15:0] CELL_COST = 16'h0100;

    typedef enum logic [1:0] {KIND_USER, KIND_LOOP, KIND_AIS} fciw_kind_t;
    typedef enum logic {RX_CELL, RX_EMIT} fciw_rx_t;

    // One byte of a stream with its delimiters
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
    } fciw_byte_t;

    // Per-connection setup
    typedef struct packed {
        logic [9:0] dlci;
        logic [7:0] vpi;
        logic [15:0] vci;
        logic de_to_clp;
        logic [7:0] credit_inc;
        logic [15:0] credit_max;
    } fciw_cfg_t;
endpackage : fciw_pkg

/* File: test/fciw_props.sv */
// Port-level checks of the interworking block
`timescale 1ns/100ps
module fciw_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Observed outputs
    input wire logic cell_ready,
    input wire fciw_pkg::fciw_byte_t frame_out,
    input wire fciw_pkg::fciw_byte_t cell_out,
    input wire logic frame_err,
    input wire logic [15:0] err_count
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_frm_open;
        $rose(frame_out.valid) |-> frame_out.first && frame_out.data == 8'h7E;
    endproperty
    a_frm_open: assert property (p_frm_open)
        else $error("no opening flag");
    property p_frm_close;
        frame_out.valid && frame_out.last |-> frame_out.data == 8'h7E;
    endproperty
    a_frm_close: assert property (p_frm_close)
        else $error("no closing flag");
    property p_frm_run;
        frame_out.valid && !frame_out.last |=> frame_out.valid;
    endproperty
    a_frm_run: assert property (p_frm_run)
        else $error("frame gap");
    property p_frm_hold;
        frame_out.valid && !frame_out.last |-> !cell_ready;
    endproperty
    a_frm_hold: assert property (p_frm_hold)
        else $error("cells taken in frame");
    property p_err_inc;
        frame_err |-> err_count == $past(err_count) + 16'h1;
    endproperty
    a_err_inc: assert property (p_err_inc)
        else $error("error not counted");
    property p_err_still;
        !frame_err |-> $stable(err_count);
    endproperty
    a_err_still: assert property (p_err_still)
        else $error("count moved");
    property p_cell_len;
        cell_out.valid && cell_out.first
            |-> ##52 (cell_out.valid && cell_out.last);
    endproperty
    a_cell_len: assert property (p_cell_len)
        else $error("cell not 53 bytes");
    property p_cell_hdr;
        cell_out.valid && cell_out.first |-> cell_out.data[7:6] == 2'h0;
    endproperty
    a_cell_hdr: assert property (p_cell_hdr)
        else $error("header format");
endmodule : fciw_props
bind fciw_top fciw_props fciw_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cell_ready(cell_ready), .frame_out(frame_out), .cell_out(cell_out),
    .frame_err(frame_err), .err_count(err_count));

/* File: test/fciw_trunk.sv */
// Cell network model that returns every cell to the block
`timescale 1ns/100ps
module fciw_trunk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Cell side
    input wire fciw_pkg::fciw_byte_t cell_out,
    input wire logic cell_ready,
    input wire logic corrupt,
    output fciw_pkg::fciw_byte_t cell_in
);
    fciw_pkg::fciw_byte_t q[$];
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            q.delete();
            cell_in <= '0;
        end else begin
            // AAL-5 cells returned in order, one frame per PDU; with corrupt set, the last byte of each cell is inverted
            if (cell_out.valid)
                q.push_back(cell_out ^ {3'h0, (corrupt && cell_out.last) ? 8'hFF : 8'h00});
            if (!cell_in.valid || cell_ready) begin
                if (q.size() > 0)
                    cell_in <= q.pop_front();
                else
                    cell_in <= '{1'b0, 1'b0, 1'b0, ~cell_in.data};
            end
        end
    end
endmodule : fciw_trunk

/* File: test/tb.sv */
// Self-checking bench of the interworking block
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic net_congested = 1'b0;
    logic fr_alarm = 1'b0;
    logic corrupt = 1'b0;
    logic pkt_ready, fr_ais, cell_ready, ferf, frame_err;
    logic [15:0] err_count;
    fciw_pkg::fciw_cfg_t cfg = '{10'h2A5, 8'h12, 16'h0345, 1'b0, 8'h40, 16'h0400};
    fciw_pkg::fciw_byte_t pkt_in = '0;
    fciw_pkg::fciw_byte_t frame_out, cell_in, cell_out;
    logic [7:0] seen[$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_ais = 0;
    fciw_top #(.AIS_CYCLES(200)) fciw_top_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .cfg(cfg), .net_congested(net_congested),
        .fr_alarm(fr_alarm), .pkt_in(pkt_in), .pkt_ready(pkt_ready),
        .frame_out(frame_out), .fr_ais(fr_ais), .cell_in(cell_in),
        .cell_ready(cell_ready), .cell_out(cell_out), .ferf(ferf),
        .frame_err(frame_err), .err_count(err_count));
    fciw_trunk fciw_trunk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cell_out(cell_out), .cell_ready(cell_ready), .corrupt(corrupt),
        .cell_in(cell_in));
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (frame_out.valid) seen.push_back(frame_out.data);
        if (fr_ais) n_ais <= n_ais + 1;
        if (cyc > 20000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [15:0] fcs(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            for (int k = 0; k < 8; k++) begin
                c = (c[0] ^ b[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
            end
        end
        return ~c;
    endfunction : fcs
    task automatic send(input logic [7:0] fr[$]);
        foreach (fr[i]) begin
            pkt_in <= '{1'b1, i == 0, i == fr.size() - 1, fr[i]};
            @(posedge sys_clk);
            while (!pkt_ready) @(posedge sys_clk);
        end
        pkt_in <= '0;
    endtask : send
    // Frame out over cells and back; acc = taken, good = played out
    task automatic t_frame(int len, logic [9:0] dl, bit acc, good, de);
        logic [7:0] fr[$];
        logic [7:0] exp[$];
        logic [15:0] f;
        logic [15:0] e0;
        e0 = err_count;
        fr = '{{dl[9:4], 2'h0}, {dl[3:0], 2'h0, de, 1'b1}};
        for (int i = 2; i < len; i++) fr.push_back(8'(i * 7 + len));
        f = fcs(fr);
        if (good) exp = {8'h7E, fr, f[7:0], f[15:8], 8'h7E};
        seen.delete();
        send(fr);
        @(posedge sys_clk);
        check("frame taken", {15'h0, acc}, {15'h0, !pkt_ready});
        for (int w = 0; w < 1000; w++) begin
            if (pkt_ready && cell_ready && seen.size() >= exp.size()) break;
            @(posedge sys_clk);
        end
        repeat (10) @(posedge sys_clk);
        check("frame length", 16'(exp.size()), 16'(seen.size()));
        foreach (exp[i]) check("frame byte", {8'h0, exp[i]}, {8'h0, seen[i]});
        check("errors", e0 + 16'(acc && !good && corrupt), err_count);
    endtask : t_frame
    // Alarm on the frame side comes back as an AIS indication
    task automatic t_ais();
        int k0;
        k0 = n_ais;
        fr_alarm <= 1'b1;
        repeat (300) @(posedge sys_clk);
        fr_alarm <= 1'b0;
        repeat (200) @(posedge sys_clk);
        check("ais seen", 16'h1, 16'(n_ais - k0 > 0));
        check("ferf", 16'h0, {15'h0, ferf});
    endtask : t_ais
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check("reset count", 16'h0, err_count);
        t_frame(40, cfg.dlci, 1, 1, 0);
        t_frame(41, cfg.dlci, 1, 1, 0);
        t_frame(3, cfg.dlci, 1, 1, 0);
        t_frame(2, cfg.dlci, 0, 0, 0);
        t_frame(20, 10'h011, 0, 0, 0);
        cfg.de_to_clp <= 1'b1;
        net_congested <= 1'b1;
        t_frame(30, cfg.dlci, 1, 1, 0);
        t_frame(30, cfg.dlci, 1, 0, 1);
        net_congested <= 1'b0;
        cfg.de_to_clp <= 1'b0;
        corrupt <= 1'b1;
        t_frame(30, cfg.dlci, 1, 0, 0);
        corrupt <= 1'b0;
        t_ais();
        give_verdict();
    end
endmodule : tb
